// file: rtl/gio_params.svh
// offsets, field positions and reset values of the general i/o port
`ifndef GIO_PARAMS_SVH
`define GIO_PARAMS_SVH

`define GIO_ADDR_W 12
`define GIO_OFS_PIN 12'h000
`define GIO_OFS_DIR 12'h004
`define GIO_OFS_OUT 12'h008
`define GIO_OFS_MCU 12'h00c
`define GIO_OFS_DIR_SET 12'h010
`define GIO_OFS_DIR_CLR 12'h014
`define GIO_OFS_OUT_SET 12'h018
`define GIO_OFS_OUT_CLR 12'h01c

`define GIO_RST_BYTE 8'h00
`define GIO_ZERO_BYTE 8'h00
`define GIO_RST_PU_OFF 1'b0
`define GIO_PU_OFF_BIT 4
`define GIO_PU_OFF_MASK 8'h10
`define GIO_RD_PAD 24'h000000
`define GIO_RD_ZERO 32'h00000000

`endif

// file: rtl/gio_pkg.sv
// types shared by the general i/o port modules
package gio_pkg;

  typedef logic [7:0] gio_byte_t;

  // per-pin override requests coming from alternate-function modules
  typedef struct packed {
    gio_byte_t puoe;
    gio_byte_t puov;
    gio_byte_t ddoe;
    gio_byte_t ddov;
    gio_byte_t pvoe;
    gio_byte_t pvov;
    gio_byte_t dieoe;
    gio_byte_t dieov;
  } gio_ovr_s;

endpackage

// file: rtl/gio_pad_if.sv
// control and input signals between the port core and its pad logic
`timescale 1ns/10ps
interface gio_pad_if;
  gio_pkg::gio_byte_t dir;
  gio_pkg::gio_byte_t port;
  logic pullup_global_off;
  logic sleep;
  gio_pkg::gio_byte_t ext_int_en;
  gio_pkg::gio_ovr_s ovr;
  gio_pkg::gio_byte_t din;

  modport core (output dir, output port, output pullup_global_off, output sleep,
    output ext_int_en, output ovr, input din);
  modport pad (input dir, input port, input pullup_global_off, input sleep,
    input ext_int_en, input ovr, output din);
endinterface

// file: rtl/gio_sync.sv
// input synchronizer: clock-high transparent latch followed by a rising-edge register
`timescale 1ns/10ps
`include "gio_params.svh"
module gio_sync (
  input logic clk,
  input logic rst_b,
  input gio_pkg::gio_byte_t din,
  output gio_pkg::gio_byte_t dout
);

  gio_pkg::gio_byte_t hold;

  // latch closes on the falling edge, so the register sees a value that settled
  // for half a period; a pin edge lands in dout after one half to one and a half periods
  always_latch begin
    if (!rst_b) begin
      hold <= `GIO_RST_BYTE;
    end else if (clk) begin
      hold <= din;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout <= `GIO_RST_BYTE;
    end else begin
      dout <= hold;
    end
  end

endmodule

// file: rtl/gio_pad.sv
// per-pin drive, pull-up and input-enable logic with alternate-function overrides
`timescale 1ns/10ps
module gio_pad (
  gio_pad_if.pad ctl,
  input logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup
);

  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_pin
      wire logic dd_eff;
      wire logic pv_eff;
      wire logic pu_plain;
      wire logic in_en;

      // overrides act per pin, so the other pins keep plain digital i/o
      assign dd_eff = ctl.ovr.ddoe[n] ? ctl.ovr.ddov[n] : ctl.dir[n];
      assign pv_eff = ctl.ovr.pvoe[n] ? ctl.ovr.pvov[n] : ctl.port[n];
      assign pu_plain = ~ctl.dir[n] & ctl.port[n] & ~ctl.pullup_global_off;
      assign pin_pullup[n] = ctl.ovr.puoe[n] ? ctl.ovr.puov[n] : pu_plain;
      assign pin_oe[n] = dd_eff;
      assign pin_out[n] = dd_eff & pv_eff;

      // deep sleep clamps a floating input to ground before the synchronizer unless its ext_int_en bit is set; a set dieoe bit replaces both with dieov
      assign in_en = ctl.ovr.dieoe[n] ? ctl.ovr.dieov[n] :
                     (~ctl.sleep | ctl.ext_int_en[n]);
      assign ctl.din[n] = pin_in[n] & in_en;
    end
  endgenerate

endmodule

// file: rtl/gio_port.sv
// general-purpose i/o port: apb register file, toggle logic and pin control
`timescale 1ns/10ps
`include "gio_params.svh"
module gio_port (
  input logic clk,
  input logic rst_b,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port pins
  input logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  // sleep controller and external interrupt enables
  input logic sleep,
  input logic [7:0] ext_int_en,
  // alternate-function overrides
  input logic [7:0] ovr_puoe,
  input logic [7:0] ovr_puov,
  input logic [7:0] ovr_ddoe,
  input logic [7:0] ovr_ddov,
  input logic [7:0] ovr_pvoe,
  input logic [7:0] ovr_pvov,
  input logic [7:0] ovr_ptoe,
  input logic [7:0] ovr_dieoe,
  input logic [7:0] ovr_dieov
);

  gio_pkg::gio_byte_t port_output_latch;
  gio_pkg::gio_byte_t port_direction;
  gio_pkg::gio_byte_t port_pin_input;
  logic pullup_global_off;

  gio_pkg::gio_byte_t next_port_output_latch;
  gio_pkg::gio_byte_t next_port_direction;
  logic next_pullup_global_off;

  gio_pad_if pad_bus ();

  // ---------------------------------------------------------------------------
  // apb phase and address decode
  // ---------------------------------------------------------------------------

  wire logic setup_ph;
  wire logic access_ph;
  wire logic wr_en;
  wire gio_pkg::gio_byte_t wdat;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  // registers live in byte lane 0; a write without that lane changes nothing
  assign wr_en = access_ph & pwrite & pstrb[0];
  assign wdat = pwdata[7:0];

  wire logic sel_pin;
  wire logic sel_dir;
  wire logic sel_out;
  wire logic sel_mcu;
  wire logic sel_dir_set;
  wire logic sel_dir_clr;
  wire logic sel_out_set;
  wire logic sel_out_clr;
  wire logic addr_hit;

  assign sel_pin = (paddr == `GIO_OFS_PIN);
  assign sel_dir = (paddr == `GIO_OFS_DIR);
  assign sel_out = (paddr == `GIO_OFS_OUT);
  assign sel_mcu = (paddr == `GIO_OFS_MCU);
  assign sel_dir_set = (paddr == `GIO_OFS_DIR_SET);
  assign sel_dir_clr = (paddr == `GIO_OFS_DIR_CLR);
  assign sel_out_set = (paddr == `GIO_OFS_OUT_SET);
  assign sel_out_clr = (paddr == `GIO_OFS_OUT_CLR);
  assign addr_hit = sel_pin | sel_dir | sel_out | sel_mcu |
                    sel_dir_set | sel_dir_clr | sel_out_set | sel_out_clr;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  // ---------------------------------------------------------------------------
  // direction register
  // ---------------------------------------------------------------------------

  wire gio_pkg::gio_byte_t dir_base;
  wire gio_pkg::gio_byte_t dir_set_mask;
  wire gio_pkg::gio_byte_t dir_clr_mask;

  assign dir_base = (wr_en & sel_dir) ? wdat : port_direction;
  // set and clear aliases give bit-wise updates without a read-modify-write
  assign dir_set_mask = (wr_en & sel_dir_set) ? wdat : `GIO_ZERO_BYTE;
  assign dir_clr_mask = (wr_en & sel_dir_clr) ? wdat : `GIO_ZERO_BYTE;
  assign next_port_direction = (dir_base | dir_set_mask) & ~dir_clr_mask;

  // ---------------------------------------------------------------------------
  // output latch register, with software and alternate-function toggling
  // ---------------------------------------------------------------------------

  wire gio_pkg::gio_byte_t out_base;
  wire gio_pkg::gio_byte_t out_set_mask;
  wire gio_pkg::gio_byte_t out_clr_mask;
  wire gio_pkg::gio_byte_t out_tgl_mask;

  assign out_base = (wr_en & sel_out) ? wdat : port_output_latch;
  assign out_set_mask = (wr_en & sel_out_set) ? wdat : `GIO_ZERO_BYTE;
  assign out_clr_mask = (wr_en & sel_out_clr) ? wdat : `GIO_ZERO_BYTE;
  // a one written to the input-pin register flips the output bit; zeros are ignored
  assign out_tgl_mask = (wr_en & sel_pin) ? wdat : `GIO_ZERO_BYTE;
  // a toggle request from an alternate function acts on its own pin only
  assign next_port_output_latch = ((out_base | out_set_mask) & ~out_clr_mask)
                                  ^ out_tgl_mask ^ ovr_ptoe;

  // ---------------------------------------------------------------------------
  // global pull-up disable
  // ---------------------------------------------------------------------------

  assign next_pullup_global_off = (wr_en & sel_mcu) ? wdat[`GIO_PU_OFF_BIT] :
                                  pullup_global_off;

  // ---------------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------------

  // asynchronous clear makes every pin without a ddoe or puoe override an input with no pull-up, clock or not
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_direction <= `GIO_RST_BYTE;
      port_output_latch <= `GIO_RST_BYTE;
      pullup_global_off <= `GIO_RST_PU_OFF;
    end else begin
      port_direction <= next_port_direction;
      port_output_latch <= next_port_output_latch;
      pullup_global_off <= next_pullup_global_off;
    end
  end

  // ---------------------------------------------------------------------------
  // pad control and input synchronizer
  // ---------------------------------------------------------------------------

  assign pad_bus.dir = port_direction;
  assign pad_bus.port = port_output_latch;
  assign pad_bus.pullup_global_off = pullup_global_off;
  assign pad_bus.sleep = sleep;
  assign pad_bus.ext_int_en = ext_int_en;
  assign pad_bus.ovr.puoe = ovr_puoe;
  assign pad_bus.ovr.puov = ovr_puov;
  assign pad_bus.ovr.ddoe = ovr_ddoe;
  assign pad_bus.ovr.ddov = ovr_ddov;
  assign pad_bus.ovr.pvoe = ovr_pvoe;
  assign pad_bus.ovr.pvov = ovr_pvov;
  assign pad_bus.ovr.dieoe = ovr_dieoe;
  assign pad_bus.ovr.dieov = ovr_dieov;

  // pin controls are combinational from the registers so a driven value is
  // back at the synchronizer within the same cycle it was written
  gio_pad u_pad (
    .ctl(pad_bus),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_pullup(pin_pullup)
  );

  // pins are sampled regardless of direction, so outputs read back too
  gio_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din(pad_bus.din),
    .dout(port_pin_input)
  );

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------

  wire gio_pkg::gio_byte_t mcu_rd;
  wire gio_pkg::gio_byte_t rd_byte;

  assign mcu_rd = pullup_global_off ? `GIO_PU_OFF_MASK : `GIO_ZERO_BYTE;
  // set and clear aliases are write-only and read as zero
  assign rd_byte = sel_pin ? port_pin_input :
                   sel_dir ? port_direction :
                   sel_out ? port_output_latch :
                   sel_mcu ? mcu_rd :
                   `GIO_ZERO_BYTE;

  // read data is taken at the end of setup, so a read right after a write to
  // the output latch still sees the old pin level; one idle cycle is needed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= `GIO_RD_ZERO;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? `GIO_RD_ZERO : {`GIO_RD_PAD, rd_byte};
      pslverr <= ~addr_hit;
    end
  end

endmodule

// file: bench/gio_port_checker.sv
// concurrent checks on the general i/o port pins and apb read responses
`timescale 1ns/10ps
`include "gio_params.svh"
module gio_port_checker (
  input logic clk,
  input logic rst_b,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pslverr,
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe,
  input logic [7:0] pin_pullup,
  input logic sleep,
  input logic [7:0] ext_int_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire wr = psel && penable && pwrite && pstrb[0];
  wire rd_set = psel && !penable && !pwrite;
  property p_dir;
    wr && paddr == `GIO_OFS_DIR |=> pin_oe == $past(pwdata[7:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("pin enables differ from direction");
  property p_out;
    wr && paddr == `GIO_OFS_OUT |=> ((pin_out ^ $past(pwdata[7:0])) & pin_oe) == 8'h00;
  endproperty
  a_out: assert property (p_out) else $error("driven level differs from output");
  property p_pu_oe;
    (pin_pullup & pin_oe) == 8'h00;
  endproperty
  a_pu_oe: assert property (p_pu_oe) else $error("pull-up on a driven pin");
  property p_pu_off;
    wr && paddr == `GIO_OFS_MCU && pwdata[`GIO_PU_OFF_BIT] |=> pin_pullup == 8'h00;
  endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up despite global off");
  property p_tog;
    wr && paddr == `GIO_OFS_PIN && pin_oe == 8'hff |=>
      pin_out == ($past(pin_out) ^ $past(pwdata[7:0]));
  endproperty
  a_tog: assert property (p_tog) else $error("toggle write wrong");
  property p_rst;
    $rose(rst_b) |-> pin_oe == 8'h00 && pin_pullup == 8'h00 && pin_out == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_unm;
    rd_set && paddr == 12'h020 |=> pslverr && prdata == `GIO_RD_ZERO;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not refused");
  property p_clamp;
    sleep [*3] ##0 (rd_set && paddr == `GIO_OFS_PIN) |=> (prdata[7:0] & ~ext_int_en) == 8'h00;
  endproperty
  a_clamp: assert property (p_clamp) else $error("input not clamped in sleep");
endmodule
bind gio_port gio_port_checker i_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pslverr, .pin_out, .pin_oe, .pin_pullup, .sleep, .ext_int_en);

// file: bench/gio_pin_model.sv
// external circuitry on the port pins
`timescale 1ns/10ps
module gio_pin_model (
  input logic clk,
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe,
  input logic [7:0] pin_pullup,
  input logic [7:0] ext_en,
  input logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // a floating pin flips every cycle so a stale level never passes for data
  logic [7:0] flt = 8'h00;
  always @(posedge clk) flt <= ~pin_in;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | flt));
endmodule

// file: bench/gio_port_tb.sv
// self-checking testbench for the general i/o port
`timescale 1ns/10ps
`include "gio_params.svh"
module gio_port_tb;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0, strb = 4'h1;
  logic pready, pslverr, err;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, ext_int_en = 8'h00, ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00, puoe = 8'h00, puov = 8'h00, ddoe = 8'h00, ddov = 8'h00;
  logic [7:0] pvoe = 8'h00, pvov = 8'h00, ptoe = 8'h00, dieoe = 8'h00, dieov = 8'h00;
  int n_mismatch = 0;
  int comparisons = 0;
  gio_port i_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup, .sleep, .ext_int_en,
    .ovr_puoe(puoe), .ovr_puov(puov), .ovr_ddoe(ddoe), .ovr_ddov(ddov), .ovr_pvoe(pvoe),
    .ovr_pvov(pvov), .ovr_ptoe(ptoe), .ovr_dieoe(dieoe), .ovr_dieov(dieov));
  gio_pin_model i_pins (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pins(input logic [23:0] e);
    chk({8'h00, pin_oe, pin_out, pin_pullup}, {8'h00, e});
  endtask
  // one transfer plus one idle cycle, so a fresh pin value is already readable
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= w ? strb : 4'h0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e});
  endtask
  task automatic t_config();
    apb(1'b1, `GIO_OFS_OUT, 8'h3c);
    apb(1'b1, `GIO_OFS_DIR, 8'h0f);
    pins(24'h0f0c30);
    apb(1'b0, `GIO_OFS_PIN, 8'h00);
    chk(rd & 32'h3f, 32'h3c);
    apb(1'b1, `GIO_OFS_DIR_SET, 8'h10);
    pins(24'h1f1c20);
    apb(1'b1, `GIO_OFS_DIR_CLR, 8'h01);
    apb(1'b1, `GIO_OFS_OUT_CLR, 8'h04);
    pins(24'h1e1820);
    rchk(`GIO_OFS_DIR, 8'h1e);
  endtask
  task automatic t_pullup();
    apb(1'b1, `GIO_OFS_MCU, 8'h10);
    pins(24'h1e1800);
    rchk(`GIO_OFS_MCU, 8'h10);
    apb(1'b1, `GIO_OFS_MCU, 8'h00);
    pins(24'h1e1820);
    apb(1'b1, `GIO_OFS_DIR_SET, 8'h20);
    pins(24'h3e3800);
  endtask
  task automatic t_toggle();
    apb(1'b1, `GIO_OFS_DIR, 8'hff);
    apb(1'b1, `GIO_OFS_PIN, 8'h81);
    pins(24'hffb900);
    apb(1'b1, `GIO_OFS_PIN, 8'h00);
    ptoe <= 8'h02;
    @(posedge clk);
    ptoe <= 8'h00;
    rchk(`GIO_OFS_OUT, 8'hbb);
    rchk(`GIO_OFS_PIN, 8'hbb);
  endtask
  task automatic t_external();
    apb(1'b1, `GIO_OFS_DIR, 8'h00);
    apb(1'b1, `GIO_OFS_OUT, 8'h00);
    ext_en <= 8'hff;
    ext_val <= 8'h5a;
    repeat (3) @(posedge clk);
    ext_val <= 8'ha5;
    rchk(`GIO_OFS_PIN, 8'h5a);
    ext_val <= 8'h3c;
    @(posedge clk);
    rchk(`GIO_OFS_PIN, 8'h3c);
    sleep <= 1'b1;
    ext_int_en <= 8'h0f;
    ext_val <= 8'hff;
    repeat (3) @(posedge clk);
    rchk(`GIO_OFS_PIN, 8'h0f);
    dieoe <= 8'h03;
    @(posedge clk);
    rchk(`GIO_OFS_PIN, 8'h0c);
    dieoe <= 8'h00;
    sleep <= 1'b0;
    ext_en <= 8'h00;
  endtask
  task automatic t_alternate();
    apb(1'b1, `GIO_OFS_DIR, 8'hf0);
    apb(1'b1, `GIO_OFS_OUT, 8'ha0);
    ddoe <= 8'h0f;
    ddov <= 8'h0f;
    pvoe <= 8'h0f;
    pvov <= 8'h05;
    @(posedge clk);
    pins(24'hffa500);
    ddoe <= 8'h00;
    pvoe <= 8'h00;
    puoe <= 8'h0f;
    puov <= 8'h05;
    @(posedge clk);
    pins(24'hf0a005);
    puoe <= 8'h00;
    apb(1'b1, 12'h020, 8'hff);
    chk({31'h0, err}, 32'h1);
    rchk(`GIO_OFS_DIR, 8'hf0);
    apb(1'b0, 12'h020, 8'h00);
    chk({31'h0, err}, 32'h1);
    // a write without byte lane 0 is ignored and not refused
    strb = 4'he;
    apb(1'b1, `GIO_OFS_DIR, 8'h00);
    strb = 4'h1;
    chk({31'h0, err}, 32'h0);
    rchk(`GIO_OFS_DIR, 8'hf0);
  endtask
  // reset in mid-run must clear the pins before any further rising edge
  task automatic t_reset();
    apb(1'b1, `GIO_OFS_MCU, 8'h10);
    rst_b <= 1'b0;
    @(negedge clk);
    pins(24'h000000);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk(`GIO_OFS_DIR, 8'h00);
    rchk(`GIO_OFS_OUT, 8'h00);
    rchk(`GIO_OFS_MCU, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    pins(24'h000000);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk(`GIO_OFS_OUT, 8'h00);
    t_config();
    t_pullup();
    t_toggle();
    t_external();
    t_alternate();
    t_reset();
    report_and_stop();
  end
endmodule
